/* File: hw/periodic_tick_interrupt.sv */
// Function
// - Taken tick loads vector address 008H
// - Every divider overflow sets tick pending flag
// - Branch needs global and tick enables set
// - Call also needs stack not full
// - Service clears pending flag and global enable
// - Source select: system, system/4, sub clock
// - Prescaler enable gates prescaler clock
// - Timer enable starts and stops divider
// - Interval is two to (4+select) cycles
// - Pending flag rise wakes, enables ignored
// - Pending flag holds until serviced or cleared
// - Entry pushes only program counter
// - Return-from-irq sets global enable again
// - Unimplemented control bits read zero
// - Pending bit5, tick enable bit2, global bit0
`timescale 1ns/1ns
`default_nettype none

module periodic_tick_interrupt
	import tick_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sub_clock,
	input wire logic stack_full,
	input wire logic return_from_irq,
	output core_call_t core,
	output logic tick_pending_flag,
	output logic global_irq_enable,
	output logic wake_request,
	output logic irq
);

	// ------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------
	tick_state_t s;
	tick_state_t next_s;

	logic setup;
	logic access;
	logic sub_rise;
	logic prescaler_clock;
	logic overflow;
	logic take;
	logic [`DIV_W-1:0] period_mask;
	logic [7:0] rd_byte;
	logic [`EV_W-1:0] ev;
	logic [`EV_W-1:0] ev_clear;

	always_comb
	begin
		next_s = s;
		next_s.core.call = 1'b0;
		next_s.wake = 1'b0;
		setup = psel & ~penable;
		access = psel & penable;
		ev_clear = '0;
		rd_byte = `BYTE_RESET;

		// ------------------------------------------------------------
		// Sub clock synchroniser
		// ------------------------------------------------------------
		next_s.sub_s1 = sub_clock;
		next_s.sub_s2 = s.sub_s1;
		next_s.sub_s3 = s.sub_s2;
		sub_rise = s.sub_s2 & ~s.sub_s3;

		// ------------------------------------------------------------
		// Prescaler clock
		// ------------------------------------------------------------
		if (s.prescaler_clock_enable)
		begin
			next_s.div4 = s.div4 + `DIV4_STEP;
		end
		case (s.prescaler_source_select)
			`SRC_SYSTEM_CLOCK:
				prescaler_clock = 1'b1;
			`SRC_SYSTEM_CLOCK_DIV4:
				prescaler_clock = (s.div4 == `DIV4_LAST);
			default:
				prescaler_clock = sub_rise;
		endcase
		prescaler_clock = prescaler_clock & s.prescaler_clock_enable;

		// ------------------------------------------------------------
		// Tick divider
		// ------------------------------------------------------------
		period_mask = `DIV_ALL_ONES >> (`PERIOD_MAX - s.tick_period_select);
		overflow = 1'b0;
		if (!s.tick_timer_enable)
		begin
			next_s.divider = '0;
		end
		else if (prescaler_clock)
		begin
			overflow = ((s.divider & period_mask) == period_mask);
			next_s.divider = s.divider + `DIV_STEP;
		end

		// ------------------------------------------------------------
		// APB setup: capture read data
		// ------------------------------------------------------------
		if (setup)
		begin
			next_s.slverr = 1'b0;
			case (paddr)
				`OFS_PRESCALER_CONTROL:
				begin
					rd_byte[`BIT_PRESCALER_CLOCK_ENABLE] = s.prescaler_clock_enable;
					rd_byte[`BIT_SRC_HI:`BIT_SRC_LO] = s.prescaler_source_select;
				end
				`OFS_TICK_CONTROL:
				begin
					rd_byte[`BIT_TICK_TIMER_ENABLE] = s.tick_timer_enable;
					rd_byte[`BIT_PERIOD_HI:`BIT_PERIOD_LO] = s.tick_period_select;
				end
				`OFS_IRQ_CONTROL:
				begin
					rd_byte[`BIT_TICK_PENDING_FLAG] = s.tick_pending_flag;
					rd_byte[`BIT_TICK_IRQ_ENABLE] = s.tick_irq_enable;
					rd_byte[`BIT_GLOBAL_IRQ_ENABLE] = s.global_irq_enable;
				end
				`OFS_EVENT_STATUS:
					rd_byte[`EV_W-1:0] = s.event_status;
				`OFS_EVENT_MASK:
					rd_byte[`EV_W-1:0] = s.event_mask;
				default:
					next_s.slverr = 1'b1;
			endcase
			next_s.prdata = {24'h00_0000, rd_byte};
		end

		// ------------------------------------------------------------
		// APB access: writes and read side effects
		// ------------------------------------------------------------
		if (access && pwrite)
		begin
			case (paddr)
				`OFS_PRESCALER_CONTROL:
				begin
					next_s.prescaler_clock_enable = pwdata[`BIT_PRESCALER_CLOCK_ENABLE];
					next_s.prescaler_source_select = pwdata[`BIT_SRC_HI:`BIT_SRC_LO];
				end
				`OFS_TICK_CONTROL:
				begin
					next_s.tick_timer_enable = pwdata[`BIT_TICK_TIMER_ENABLE];
					next_s.tick_period_select = pwdata[`BIT_PERIOD_HI:`BIT_PERIOD_LO];
				end
				`OFS_IRQ_CONTROL:
				begin
					next_s.tick_pending_flag = pwdata[`BIT_TICK_PENDING_FLAG];
					next_s.tick_irq_enable = pwdata[`BIT_TICK_IRQ_ENABLE];
					next_s.global_irq_enable = pwdata[`BIT_GLOBAL_IRQ_ENABLE];
				end
				`OFS_EVENT_MASK:
					next_s.event_mask = pwdata[`EV_W-1:0];
				default:
				begin
				end
			endcase
		end
		if (access && !pwrite && paddr == `OFS_EVENT_STATUS && !s.slverr)
		begin
			ev_clear = s.prdata[`EV_W-1:0];
		end

		// ------------------------------------------------------------
		// Vectored call
		// ------------------------------------------------------------
		take = s.tick_pending_flag & s.tick_irq_enable & s.global_irq_enable & ~stack_full;
		if (take)
		begin
			next_s.tick_pending_flag = 1'b0;
			next_s.global_irq_enable = 1'b0;
			next_s.core.call = 1'b1;
			next_s.core.vector = `TICK_VECTOR_ADDR;
		end
		if (return_from_irq)
		begin
			next_s.global_irq_enable = 1'b1;
		end
		if (overflow)
		begin
			next_s.tick_pending_flag = 1'b1;
		end

		// ------------------------------------------------------------
		// Wake-up and event status
		// ------------------------------------------------------------
		next_s.wake = next_s.tick_pending_flag & ~s.tick_pending_flag;
		ev = '0;
		ev[`EV_OVERFLOW] = overflow;
		ev[`EV_VECTOR_CALL] = take;
		ev[`EV_WAKE] = next_s.wake;
		next_s.event_status = (s.event_status & ~ev_clear) | ev;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign prdata = s.prdata;
	assign pready = 1'b1;
	assign pslverr = s.slverr & psel & penable;
	assign core = s.core;
	assign tick_pending_flag = s.tick_pending_flag;
	assign global_irq_enable = s.global_irq_enable;
	assign wake_request = s.wake;
	assign irq = |(s.event_status & s.event_mask);

endmodule

`default_nettype wire

/* File: hw/tick_defines.svh */
`ifndef TICK_DEFINES_SVH
`define TICK_DEFINES_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define ADDR_W 12
`define OFS_PRESCALER_CONTROL 12'h000
`define OFS_TICK_CONTROL 12'h004
`define OFS_IRQ_CONTROL 12'h008
`define OFS_EVENT_STATUS 12'h00c
`define OFS_EVENT_MASK 12'h010

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_PRESCALER_CLOCK_ENABLE 2
`define BIT_SRC_HI 1
`define BIT_SRC_LO 0
`define BIT_TICK_TIMER_ENABLE 7
`define BIT_PERIOD_HI 2
`define BIT_PERIOD_LO 0
`define BIT_TICK_PENDING_FLAG 5
`define BIT_TICK_IRQ_ENABLE 2
`define BIT_GLOBAL_IRQ_ENABLE 0
`define EV_OVERFLOW 0
`define EV_VECTOR_CALL 1
`define EV_WAKE 2
`define EV_W 3

// ------------------------------------------------------------
// Codes, reset values and counts
// ------------------------------------------------------------
`define SRC_SYSTEM_CLOCK 2'h0
`define SRC_SYSTEM_CLOCK_DIV4 2'h1
`define DIV4_LAST 2'h3
`define DIV4_STEP 2'h1
`define DIV_W 11
`define DIV_ALL_ONES 11'h7ff
`define DIV_STEP 11'h001
`define PERIOD_MAX 3'h7
`define VECTOR_W 12
`define TICK_VECTOR_ADDR 12'h008
`define BYTE_RESET 8'h00
`define WORD_ZERO 32'h0000_0000

`endif

/* File: hw/tick_pkg.sv */
package tick_pkg;
`include "tick_defines.svh"

	// ------------------------------------------------------------
	// Core-facing call request
	// ------------------------------------------------------------
	typedef struct packed
	{
		logic call;
		logic [`VECTOR_W-1:0] vector;
	} core_call_t;

	// ------------------------------------------------------------
	// Whole state of the block
	// ------------------------------------------------------------
	typedef struct packed
	{
		logic prescaler_clock_enable;
		logic [1:0] prescaler_source_select;
		logic tick_timer_enable;
		logic [2:0] tick_period_select;
		logic tick_pending_flag;
		logic tick_irq_enable;
		logic global_irq_enable;
		logic [`EV_W-1:0] event_status;
		logic [`EV_W-1:0] event_mask;
		logic [`DIV_W-1:0] divider;
		logic [1:0] div4;
		logic sub_s1;
		logic sub_s2;
		logic sub_s3;
		logic [31:0] prdata;
		logic slverr;
		logic wake;
		core_call_t core;
	} tick_state_t;
endpackage

/* File: dv/tick_chk_props.sv */
`timescale 1ns/1ns
`default_nettype none
module tick_chk
	import tick_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic stack_full,
	input wire logic return_from_irq,
	input wire core_call_t core,
	input wire logic tick_pending_flag,
	input wire logic global_irq_enable,
	input wire logic wake_request
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	call_vector_a: assert property (core.call |-> core.vector == 12'h008) else $error("bad vector");
	call_gate_a: assert property (core.call |-> $past(tick_pending_flag && global_irq_enable && !stack_full))
		else $error("call without cause");
	call_clears_a: assert property (core.call |-> !global_irq_enable ##1 !core.call) else $error("call left enable");
	wake_rise_a: assert property (wake_request == $rose(tick_pending_flag)) else $error("wake mismatch");
	pending_hold_a: assert property ($fell(tick_pending_flag) |-> core.call ||
		$past(psel && penable && pwrite && paddr == 12'h008)) else $error("pending dropped");
	return_from_irq_global_a: assert property (return_from_irq |=> global_irq_enable) else $error("no enable");
	tick_zeros_a: assert property (psel && penable && !pwrite && paddr == 12'h004 |->
		(prdata & 32'hffff_ff78) == 32'h0) else $error("tick bits");
	presc_zeros_a: assert property (psel && penable && !pwrite && paddr == 12'h000 |->
		prdata[31:3] == 29'h0) else $error("prescaler bits");
	unmapped_err_a: assert property (psel && penable && paddr > 12'h010 |-> pslverr) else $error("no error");
endmodule
bind periodic_tick_interrupt tick_chk tick_chk_inst (.*);
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import tick_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, sub_clock, stack_full, return_from_irq, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, tick_pending_flag, global_irq_enable, wake_request, irq;
	core_call_t core;
	int errors, checks_done, cyc, t1, n;

	periodic_tick_interrupt periodic_tick_interrupt_inst (.*);

	initial
	begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	initial
	begin
		sub_clock = 0;
		forever #30 sub_clock = ~sub_clock;
	end
	always @(posedge pclk) cyc <= cyc + 1;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic report_and_stop;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bound(input int lim);
		if (n >= lim)
		begin
			check(0, 1);
			report_and_stop();
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1 && n < 50);
		bound(50);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic wait_pend;
		n = 0;
		while (tick_pending_flag !== 1 && n < 5000)
		begin
			@(posedge pclk);
			n++;
		end
		bound(5000);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic regs;
		for (int i = 0; i < 5; i++)
		begin
			apb(0, 12'(4 * i), 32'h0);
			check(rd, 32'h0);
		end
		apb(1, 12'h000, 32'hff);
		apb(0, 12'h000, 32'h0);
		check(rd, 32'h7);
		apb(1, 12'h004, 32'hff);
		apb(0, 12'h004, 32'h0);
		check(rd, 32'h87);
		apb(1, 12'h004, 32'h0);
		apb(1, 12'h008, 32'hda);
		apb(0, 12'h008, 32'h0);
		check(rd, 32'h0);
		apb(0, 12'h014, 32'h0);
		check({31'h0, err}, 32'h1);
	endtask
	task automatic period(input logic [1:0] src, input logic [2:0] sel, input int exp);
		apb(1, 12'h004, 32'h0);
		apb(1, 12'h008, 32'h0);
		apb(1, 12'h000, {29'h0, 1'b1, src});
		apb(1, 12'h004, {24'h0, 5'h10, sel});
		wait_pend();
		t1 = cyc;
		apb(1, 12'h008, 32'h0);
		wait_pend();
		check(cyc - t1, exp);
	endtask
	task automatic gating;
		apb(1, 12'h000, 32'h0);
		apb(1, 12'h008, 32'h0);
		repeat (40) @(posedge pclk);
		check(tick_pending_flag, 0);
		apb(1, 12'h000, 32'h4);
		apb(1, 12'h004, 32'h0);
		apb(1, 12'h008, 32'h0);
		repeat (40) @(posedge pclk);
		check(tick_pending_flag, 0);
	endtask
	task automatic irqs;
		apb(0, 12'h00c, 32'h0);
		apb(1, 12'h010, 32'h1);
		apb(1, 12'h008, 32'h4);
		apb(1, 12'h004, 32'h80);
		wait_pend();
		repeat (40) @(posedge pclk);
		check({tick_pending_flag, irq, core.call}, 3'h6);
		apb(1, 12'h004, 32'h0);
		stack_full <= 1;
		apb(1, 12'h008, 32'h25);
		repeat (10) @(posedge pclk);
		check({tick_pending_flag, global_irq_enable}, 2'h3);
		stack_full <= 0;
		n = 0;
		while (core.call !== 1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		bound(20);
		check({core.vector, tick_pending_flag, global_irq_enable}, 14'h020);
		return_from_irq <= 1;
		@(posedge pclk);
		return_from_irq <= 0;
		@(posedge pclk);
		check(global_irq_enable, 1);
		apb(0, 12'h00c, 32'h0);
		check(rd, 32'h7);
		apb(0, 12'h00c, 32'h0);
		check({rd[3:0], irq}, 5'h0);
	endtask
	task automatic wake_block;
		apb(1, 12'h004, 32'h0);
		apb(1, 12'h008, 32'h20);
		apb(0, 12'h00c, 32'h0);
		apb(1, 12'h004, 32'h80);
		repeat (40) @(posedge pclk);
		check({wake_request, tick_pending_flag}, 2'h1);
		apb(1, 12'h004, 32'h0);
		apb(0, 12'h00c, 32'h0);
		check(rd, 32'h1);
	endtask

	initial
	begin
		{psel, penable, pwrite, stack_full, return_from_irq} = '0;
		paddr = '0;
		pwdata = '0;
		presetn = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		regs();
		period(2'h0, 3'h0, 16);
		period(2'h0, 3'h7, 2048);
		period(2'h1, 3'h1, 128);
		period(2'h2, 3'h0, 96);
		period(2'h3, 3'h0, 96);
		gating();
		irqs();
		wake_block();
		report_and_stop();
	end
endmodule
`default_nettype wire
